// ---- core/gwe_pkg.sv ----
// Constants, register map and pin maps of the wake/event GPIO port block.
// Assumes pins are numbered (port-1)*8+bit, ports one to six; sources 48/49 are tach inputs.
package gwe_pkg;
   localparam int NUM_PINS  = 48;
   localparam int NUM_SRC   = 50;
   localparam int NUM_PORTS = 6;
   localparam int NUM_EE    = 6;
   localparam int NUM_WAKE  = 4;
   localparam int NUM_MGMT  = 3;

   // Register offsets
   localparam logic [7:0] ADDR_DATA_BASE = 8'h4b;
   localparam logic [7:0] ADDR_CFG_BASE  = 8'h80;
   localparam logic [7:0] ADDR_WAKE_STS  = 8'h30;
   localparam logic [7:0] ADDR_WAKE_EN   = 8'h34;
   localparam logic [7:0] ADDR_MGMT_STS  = 8'h38;
   localparam logic [7:0] ADDR_MGMT_EN   = 8'h3b;
   localparam logic [7:0] ADDR_SUMM_STS  = 8'h3e;
   localparam logic [7:0] ADDR_EE_MODE   = 8'h3f;
   localparam logic [7:0] ADDR_CTRL      = 8'h40;

   // Field positions
   localparam int CFG_DIR        = 0;
   localparam int CFG_POL        = 1;
   localparam int CFG_OD         = 7;
   localparam int CTRL_WAKE_EN   = 0;
   localparam int CTRL_JOY_ALT   = 1;
   localparam int CTRL_DRATE_ALT = 2;
   localparam int CTRL_MGMT_ALT  = 3;

   // Reset values
   localparam logic [7:0]  CFG_RST_INPUT   = 8'h01;
   localparam logic [7:0]  CFG_RST_OUT_LOW = 8'h00;
   localparam logic [47:0] PIN_RST_OUT     = 48'h0008000c0000;
   localparam logic [7:0]  CTRL_RST        = 8'h00;

   // Special pins
   localparam int PIN_JOY_FIRST  = 4;
   localparam int PIN_JOY_LAST   = 7;
   localparam int PIN_MGMT_ALT   = 15;
   localparam int PIN_DRATE      = 27;

   localparam logic [7:0] PORT_MASK [NUM_PORTS] = '{8'hff, 8'hf7, 8'hff, 8'h0f, 8'hff, 8'h03};
   localparam int WAKE_MAP [NUM_WAKE][8] = '{'{0, 1, 2, 3, 4, 5, 6, 7},
                                           '{8, 9, 10, 0, 12, 13, 14, 15},
                                           '{16, 17, 18, 19, 25, 27, 40, 41},
                                           '{32, 33, 34, 35, 36, 37, 38, 39}};
   localparam logic [7:0] WAKE_MASK [NUM_WAKE] = '{8'hff, 8'hf7, 8'hff, 8'hff};
   localparam int MGMT_MAP [NUM_MGMT][8] = '{'{8, 9, 10, 0, 12, 13, 14, 40},
                                           '{16, 17, 18, 19, 25, 26, 27, 41},
                                           '{36, 37, 38, 39, 48, 49, 0, 0}};
   localparam logic [7:0] MGMT_MASK [NUM_MGMT] = '{8'hf7, 8'hff, 8'h3f};
   localparam int EE_MAP [NUM_EE] = '{9, 10, 25, 27, 40, 41};
   localparam logic [49:0] EE_CAP_MASK = 50'h3000a000600;
endpackage

// ---- core/gwe_sync.sv ----
// Two-stage synchroniser for a vector of unrelated asynchronous levels.
// Assumes each bit is independent; no bus coherence across bits is implied.
`timescale 1ns/100ps
`default_nettype none
module gwe_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   // The first stage feeds only the second stage
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

// ---- core/gwe_port.sv ----
// Wake and management-interrupt GPIO port logic: config, data, edge status, pin drive.
// Assumes a single-cycle register port and asynchronous pins and tach inputs.
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Config bit 0 selects direction, 1 input
// - Config bit 1 inverts input and output
// - Config bit 7 selects open-drain driver
// - Polarity ignored for drive-rate, joystick, either-edge
// - Joystick alt pins open-drain, non-inverted
// - Input read returns pin, polarity applied
// - Data writes to input pins ignored
// - Output pin driven by data, polarity applied
// - Output read returns last written value
// - Output pins set no wake or management status outside either-edge mode
// - Polarity picks rising or falling wake edge
// - Wake needs status, enable and global enable
// - Wake status clears only on written one
// - Four wake status/enable register pairs
// - Three management pairs, last holds tach bits
// - Either-edge mode sets status on both edges
// - Either-edge ignores direction/drive; read still inverted
// - Either-edge pin interrupts only in that mode
// - Summary register, both edges, write-one clear
// - Status sets regardless of enables or mode
// - Reset drives three pins low, drive-rate off
// - Management interrupt from any enabled status, either-edge pins only in that mode
// - Global wake enable low blocks wake output
module gwe_port (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output var  logic [7:0]  rdata,
   input  wire logic [47:0] pin_in,
   output var  logic [47:0] pin_out,
   output var  logic [47:0] pin_oe,
   input  wire logic        fan_speed_input_one,
   input  wire logic        fan_speed_input_two,
   input  wire logic [3:0]  joystick_axis_drive,
   input  wire logic        drive_rate_drive,
   output var  logic        wake_event,
   output var  logic        mgmt_irq
);
   logic [7:0]                  cfg [gwe_pkg::NUM_PINS];
   logic [gwe_pkg::NUM_PINS-1:0] data_q;
   logic [7:0]                  wake_sts [gwe_pkg::NUM_WAKE];
   logic [7:0]                  wake_en [gwe_pkg::NUM_WAKE];
   logic [7:0]                  mgmt_sts [gwe_pkg::NUM_MGMT];
   logic [7:0]                  mgmt_en [gwe_pkg::NUM_MGMT];
   logic [gwe_pkg::NUM_EE-1:0]   summ_sts;
   logic [gwe_pkg::NUM_EE-1:0]   either_edge_event_mode;
   logic [7:0]                  ctrl;
   logic [gwe_pkg::NUM_SRC-1:0]  src_sync;
   logic [gwe_pkg::NUM_SRC-1:0]  src_prev;
   logic [gwe_pkg::NUM_SRC-1:0]  rise;
   logic [gwe_pkg::NUM_SRC-1:0]  fall;
   logic [gwe_pkg::NUM_SRC-1:0]  ee_on;
   logic [gwe_pkg::NUM_SRC-1:0]  evt;
   logic [gwe_pkg::NUM_SRC-1:0]  allow;
   logic [gwe_pkg::NUM_PINS-1:0] is_input;
   logic [gwe_pkg::NUM_PINS-1:0] next_pin_out;
   logic [gwe_pkg::NUM_PINS-1:0] next_pin_oe;
   logic [7:0]                  next_rdata;
   logic                        next_wake;
   logic                        next_mgmt;

   // Tach inputs ride along as sources 48 and 49
   gwe_sync #(
      .WIDTH (gwe_pkg::NUM_SRC)
   ) u_sync (
      .core_clk (core_clk),
      .rstn     (rstn),
      .d        ({fan_speed_input_two, fan_speed_input_one, pin_in}),
      .q        (src_sync)
   );

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         src_prev <= '0;
      end else begin
         src_prev <= src_sync;
      end
   end

   assign rise = src_sync & ~src_prev;
   assign fall = ~src_sync & src_prev;

   // Event qualification per source
   always_comb begin
      ee_on = '0;
      for (int k = 0; k < gwe_pkg::NUM_EE; k++) begin
         ee_on[gwe_pkg::EE_MAP[k]] = either_edge_event_mode[k];
      end
      for (int i = 0; i < gwe_pkg::NUM_PINS; i++) begin
         is_input[i] = cfg[i][gwe_pkg::CFG_DIR] | ee_on[i];
         if (ee_on[i]) begin
            evt[i] = rise[i] | fall[i];
         end else if (cfg[i][gwe_pkg::CFG_DIR]) begin
            evt[i] = cfg[i][gwe_pkg::CFG_POL] ? fall[i] : rise[i];
         end else begin
            evt[i] = 1'b0;
         end
      end
      evt[gwe_pkg::NUM_PINS]   = rise[gwe_pkg::NUM_PINS];
      evt[gwe_pkg::NUM_PINS+1] = rise[gwe_pkg::NUM_PINS+1];
      // Either-edge pins contribute to outputs only in that mode
      allow = ~gwe_pkg::EE_CAP_MASK | ee_on;
   end

   // Config registers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < gwe_pkg::NUM_PINS; i++) begin
            cfg[i] <= gwe_pkg::PIN_RST_OUT[i] ? gwe_pkg::CFG_RST_OUT_LOW
                                              : gwe_pkg::CFG_RST_INPUT;
         end
      end else if (wr_stb) begin
         for (int i = 0; i < gwe_pkg::NUM_PINS; i++) begin
            if (addr == gwe_pkg::ADDR_CFG_BASE + 8'(i)) begin
               cfg[i] <= wdata;
            end
         end
      end
   end

   // Data registers; input bits keep their stored value
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         data_q <= '0;
      end else if (wr_stb) begin
         for (int p = 0; p < gwe_pkg::NUM_PORTS; p++) begin
            for (int b = 0; b < 8; b++) begin
               if (addr == gwe_pkg::ADDR_DATA_BASE + 8'(p) && gwe_pkg::PORT_MASK[p][b] &&
                   !is_input[p*8+b]) begin
                  data_q[p*8+b] <= wdata[b];
               end
            end
         end
      end
   end

   // Enables, mode and control
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int g = 0; g < gwe_pkg::NUM_WAKE; g++) begin
            wake_en[g] <= '0;
         end
         for (int g = 0; g < gwe_pkg::NUM_MGMT; g++) begin
            mgmt_en[g] <= '0;
         end
         either_edge_event_mode <= '0;
         ctrl                   <= gwe_pkg::CTRL_RST;
      end else if (wr_stb) begin
         for (int g = 0; g < gwe_pkg::NUM_WAKE; g++) begin
            if (addr == gwe_pkg::ADDR_WAKE_EN + 8'(g)) begin
               wake_en[g] <= wdata & gwe_pkg::WAKE_MASK[g];
            end
         end
         for (int g = 0; g < gwe_pkg::NUM_MGMT; g++) begin
            if (addr == gwe_pkg::ADDR_MGMT_EN + 8'(g)) begin
               mgmt_en[g] <= wdata & gwe_pkg::MGMT_MASK[g];
            end
         end
         if (addr == gwe_pkg::ADDR_EE_MODE) begin
            either_edge_event_mode <= wdata[gwe_pkg::NUM_EE-1:0];
         end
         if (addr == gwe_pkg::ADDR_CTRL) begin
            ctrl <= wdata;
         end
      end
   end

   // Sticky status; a new event in the clearing cycle wins
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int g = 0; g < gwe_pkg::NUM_WAKE; g++) begin
            wake_sts[g] <= '0;
         end
         for (int g = 0; g < gwe_pkg::NUM_MGMT; g++) begin
            mgmt_sts[g] <= '0;
         end
         summ_sts <= '0;
      end else begin
         for (int g = 0; g < gwe_pkg::NUM_WAKE; g++) begin
            for (int b = 0; b < 8; b++) begin
               if (gwe_pkg::WAKE_MASK[g][b]) begin
                  wake_sts[g][b] <= (wake_sts[g][b] & ~(wr_stb && wdata[b] &&
                                     addr == gwe_pkg::ADDR_WAKE_STS + 8'(g))) |
                                    evt[gwe_pkg::WAKE_MAP[g][b]];
               end
            end
         end
         for (int g = 0; g < gwe_pkg::NUM_MGMT; g++) begin
            for (int b = 0; b < 8; b++) begin
               if (gwe_pkg::MGMT_MASK[g][b]) begin
                  mgmt_sts[g][b] <= (mgmt_sts[g][b] & ~(wr_stb && wdata[b] &&
                                     addr == gwe_pkg::ADDR_MGMT_STS + 8'(g))) |
                                    evt[gwe_pkg::MGMT_MAP[g][b]];
               end
            end
         end
         for (int k = 0; k < gwe_pkg::NUM_EE; k++) begin
            summ_sts[k] <= (summ_sts[k] & ~(wr_stb && wdata[k] &&
                            addr == gwe_pkg::ADDR_SUMM_STS)) |
                           rise[gwe_pkg::EE_MAP[k]] | fall[gwe_pkg::EE_MAP[k]];
         end
      end
   end

   // Wake and management outputs
   always_comb begin
      next_wake = 1'b0;
      next_mgmt = 1'b0;
      for (int g = 0; g < gwe_pkg::NUM_WAKE; g++) begin
         for (int b = 0; b < 8; b++) begin
            next_wake = next_wake | (wake_sts[g][b] & wake_en[g][b] &
                                     allow[gwe_pkg::WAKE_MAP[g][b]]);
         end
      end
      next_wake = next_wake & ctrl[gwe_pkg::CTRL_WAKE_EN];
      for (int g = 0; g < gwe_pkg::NUM_MGMT; g++) begin
         for (int b = 0; b < 8; b++) begin
            next_mgmt = next_mgmt | (mgmt_sts[g][b] & mgmt_en[g][b] &
                                     allow[gwe_pkg::MGMT_MAP[g][b]]);
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wake_event <= 1'b0;
         mgmt_irq   <= 1'b0;
      end else begin
         wake_event <= next_wake;
         mgmt_irq   <= next_mgmt;
      end
   end

   // Pin drive
   always_comb begin
      logic val;
      logic od;
      logic en;
      val = 1'b0;
      od  = 1'b0;
      en  = 1'b0;
      for (int i = 0; i < gwe_pkg::NUM_PINS; i++) begin
         val = data_q[i] ^ cfg[i][gwe_pkg::CFG_POL];
         od  = cfg[i][gwe_pkg::CFG_OD];
         en  = !is_input[i];
         if (ctrl[gwe_pkg::CTRL_JOY_ALT] && i >= gwe_pkg::PIN_JOY_FIRST &&
             i <= gwe_pkg::PIN_JOY_LAST) begin
            val = joystick_axis_drive[i-gwe_pkg::PIN_JOY_FIRST];
            od  = 1'b1;
            en  = 1'b1;
         end else if (ctrl[gwe_pkg::CTRL_DRATE_ALT] && i == gwe_pkg::PIN_DRATE) begin
            val = drive_rate_drive;
            en  = 1'b1;
         end else if (ctrl[gwe_pkg::CTRL_MGMT_ALT] && i == gwe_pkg::PIN_MGMT_ALT) begin
            // Active low at polarity 0
            val = ~mgmt_irq ^ cfg[i][gwe_pkg::CFG_POL];
            en  = 1'b1;
         end
         next_pin_out[i] = od ? 1'b0 : val;
         next_pin_oe[i]  = od ? (en & ~val) : en;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pin_out <= '0;
         pin_oe  <= gwe_pkg::PIN_RST_OUT;
      end else begin
         pin_out <= next_pin_out;
         pin_oe  <= next_pin_oe;
      end
   end

   // Register read
   always_comb begin
      next_rdata = 8'h00;
      for (int p = 0; p < gwe_pkg::NUM_PORTS; p++) begin
         if (addr == gwe_pkg::ADDR_DATA_BASE + 8'(p)) begin
            for (int b = 0; b < 8; b++) begin
               next_rdata[b] = gwe_pkg::PORT_MASK[p][b] &
                               (is_input[p*8+b] ? (src_sync[p*8+b] ^
                                cfg[p*8+b][gwe_pkg::CFG_POL]) : data_q[p*8+b]);
            end
         end
      end
      for (int i = 0; i < gwe_pkg::NUM_PINS; i++) begin
         if (addr == gwe_pkg::ADDR_CFG_BASE + 8'(i)) begin
            next_rdata = cfg[i];
         end
      end
      for (int g = 0; g < gwe_pkg::NUM_WAKE; g++) begin
         if (addr == gwe_pkg::ADDR_WAKE_STS + 8'(g)) begin
            next_rdata = wake_sts[g];
         end
         if (addr == gwe_pkg::ADDR_WAKE_EN + 8'(g)) begin
            next_rdata = wake_en[g];
         end
      end
      for (int g = 0; g < gwe_pkg::NUM_MGMT; g++) begin
         if (addr == gwe_pkg::ADDR_MGMT_STS + 8'(g)) begin
            next_rdata = mgmt_sts[g];
         end
         if (addr == gwe_pkg::ADDR_MGMT_EN + 8'(g)) begin
            next_rdata = mgmt_en[g];
         end
      end
      if (addr == gwe_pkg::ADDR_SUMM_STS) begin
         next_rdata = {2'b00, summ_sts};
      end
      if (addr == gwe_pkg::ADDR_EE_MODE) begin
         next_rdata = {2'b00, either_edge_event_mode};
      end
      if (addr == gwe_pkg::ADDR_CTRL) begin
         next_rdata = ctrl;
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rd_stb ? next_rdata : 8'h00;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   sequence s_ee_fall;
      fall[9] && either_edge_event_mode[0];
   endsequence
   sequence s_ee_set;
      summ_sts[0] && wake_sts[1][1] && mgmt_sts[0][1];
   endsequence

   property p_wake_gate;
      !ctrl[gwe_pkg::CTRL_WAKE_EN] |=> !wake_event;
   endproperty
   a_wake_gate: assert property (p_wake_gate) else $error("wake raised while globally off");

   property p_w1c;
      wr_stb && addr == gwe_pkg::ADDR_WAKE_STS && wdata[0] && !evt[0] |=> !wake_sts[0][0];
   endproperty
   a_w1c: assert property (p_w1c) else $error("wake status not cleared by one");

   property p_w0_keep;
      wr_stb && addr == gwe_pkg::ADDR_WAKE_STS && wdata == 8'h00 && wake_sts[0][0]
         |=> wake_sts[0][0];
   endproperty
   a_w0_keep: assert property (p_w0_keep) else $error("wake status lost on zero write");

   property p_rise_sets;
      rise[0] && cfg[0][gwe_pkg::CFG_DIR] && !cfg[0][gwe_pkg::CFG_POL] |=> wake_sts[0][0];
   endproperty
   a_rise_sets: assert property (p_rise_sets) else $error("rising edge missed");

   property p_fall_only;
      rise[0] && !fall[0] && cfg[0][gwe_pkg::CFG_DIR] && cfg[0][gwe_pkg::CFG_POL] &&
         !wake_sts[0][0] |=> !wake_sts[0][0];
   endproperty
   a_fall_only: assert property (p_fall_only) else $error("wrong edge set status");

   property p_out_excl;
      !cfg[8][gwe_pkg::CFG_DIR] && !wake_sts[1][0] |=> !wake_sts[1][0];
   endproperty
   a_out_excl: assert property (p_out_excl) else $error("output pin set status");

   property p_ee_both;
      s_ee_fall |=> s_ee_set;
   endproperty
   a_ee_both: assert property (p_ee_both) else $error("either-edge fall not recorded");

   property p_summ_any;
      fall[9] |=> summ_sts[0];
   endproperty
   a_summ_any: assert property (p_summ_any) else $error("summary missed edge");

   property p_tach_irq;
      mgmt_sts[2][4] && mgmt_en[2][4] |=> mgmt_irq;
   endproperty
   a_tach_irq: assert property (p_tach_irq) else $error("management irq not raised");

   property p_in_write;
      wr_stb && addr == gwe_pkg::ADDR_DATA_BASE && cfg[0][gwe_pkg::CFG_DIR]
         |=> data_q[0] == $past(data_q[0]);
   endproperty
   a_in_write: assert property (p_in_write) else $error("input data bit written");

   property p_out_drive;
      !cfg[8][gwe_pkg::CFG_DIR] && !cfg[8][gwe_pkg::CFG_OD]
         |=> pin_oe[8] && pin_out[8] == ($past(data_q[8]) ^ $past(cfg[8][gwe_pkg::CFG_POL]));
   endproperty
   a_out_drive: assert property (p_out_drive) else $error("output pin drive wrong");
endmodule
`default_nettype wire

// ---- tb/gwe_pin_model.sv ----
// Board-side model of the port pins: resolves every pad level.
// Assumes the board drives each pin whenever the device leaves it undriven.
`timescale 1ns/100ps
`default_nettype none
module gwe_pin_model (
   input  wire logic [47:0] pin_out,
   input  wire logic [47:0] pin_oe,
   input  wire logic [47:0] board_level,
   output var  logic [47:0] pin_level
);
   // A released open-drain pad falls back to the board level
   always_comb begin
      for (int i = 0; i < 48; i++) begin
         pin_level[i] = pin_oe[i] ? pin_out[i] : board_level[i];
      end
   end
endmodule
`default_nettype wire

// ---- tb/gwe_port_tb_top.sv ----
// Self-checking bench for the wake/event GPIO port block.
// Assumes the register port answers one cycle after a read strobe.
`timescale 1ns/100ps
`default_nettype none
module gwe_port_tb_top;
   logic        core_clk;
   logic        rstn;
   logic [7:0]  addr;
   logic [7:0]  wdata;
   logic        wr_stb;
   logic        rd_stb;
   logic [7:0]  rdata;
   logic [47:0] pin_in;
   logic [47:0] pin_out;
   logic [47:0] pin_oe;
   logic [47:0] board;
   logic        fan1;
   logic        fan2;
   logic [3:0]  joy;
   logic        drate;
   logic        wake_event;
   logic        mgmt_irq;
   int          bad_count;
   int          checked;

   gwe_port gwe_port_inst (
      .core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .fan_speed_input_one(fan1),
      .fan_speed_input_two(fan2), .joystick_axis_drive(joy),
      .drive_rate_drive(drate), .wake_event(wake_event), .mgmt_irq(mgmt_irq));

   gwe_pin_model gwe_pin_model_inst (
      .pin_out(pin_out), .pin_oe(pin_oe), .board_level(board), .pin_level(pin_in));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic print_verdict();
      $display("mismatches %0d, comparisons %0d", bad_count, checked);
      if (bad_count == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1;
      chk(rdata, e);
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic t_reset();
      rdchk(gwe_pkg::ADDR_CFG_BASE + 8'd18, 8'h00);
      rdchk(gwe_pkg::ADDR_CFG_BASE, 8'h01);
      chk({6'h00, pin_oe[35], pin_out[35]}, 8'h02);
      chk({7'h00, pin_oe[18]}, 8'h01);
      rdchk(8'h20, 8'h00);
   endtask

   task automatic t_output();
      // Written while still an input, so the stored bit must stay low
      wr(gwe_pkg::ADDR_DATA_BASE + 8'd1, 8'h01);
      wr(gwe_pkg::ADDR_CFG_BASE + 8'd8, 8'h00);
      wt(2);
      chk({6'h00, pin_oe[8], pin_out[8]}, 8'h02);
      wr(gwe_pkg::ADDR_DATA_BASE + 8'd1, 8'h01);
      wt(2);
      chk({6'h00, pin_oe[8], pin_out[8]}, 8'h03);
      wr(gwe_pkg::ADDR_CFG_BASE + 8'd8, 8'h02);
      wt(2);
      chk({7'h00, pin_out[8]}, 8'h00);
      rdchk(gwe_pkg::ADDR_DATA_BASE + 8'd1, 8'h01);
      wr(gwe_pkg::ADDR_CFG_BASE + 8'd8, 8'h80);
      wt(2);
      chk({7'h00, pin_oe[8]}, 8'h00);
      wr(gwe_pkg::ADDR_DATA_BASE + 8'd1, 8'h00);
      wt(2);
      chk({6'h00, pin_oe[8], pin_out[8]}, 8'h02);
      rdchk(gwe_pkg::ADDR_MGMT_STS, 8'h00);
      rdchk(gwe_pkg::ADDR_WAKE_STS + 8'd1, 8'h00);
   endtask

   task automatic t_wake();
      wr(gwe_pkg::ADDR_DATA_BASE, 8'hff);
      rdchk(gwe_pkg::ADDR_DATA_BASE, 8'h00);
      @(posedge core_clk);
      board[0] <= 1'b1;
      wt(6);
      rdchk(gwe_pkg::ADDR_DATA_BASE, 8'h01);
      rdchk(gwe_pkg::ADDR_WAKE_STS, 8'h01);
      wr(gwe_pkg::ADDR_WAKE_EN, 8'h01);
      wt(2);
      chk({7'h00, wake_event}, 8'h00);
      wr(gwe_pkg::ADDR_CTRL, 8'h01);
      wt(2);
      chk({7'h00, wake_event}, 8'h01);
      wr(gwe_pkg::ADDR_WAKE_STS, 8'h00);
      rdchk(gwe_pkg::ADDR_WAKE_STS, 8'h01);
      wr(gwe_pkg::ADDR_WAKE_STS, 8'h01);
      wt(2);
      chk({7'h00, wake_event}, 8'h00);
      // Polarity flips while the pin is high, so no spurious edge appears
      wr(gwe_pkg::ADDR_CFG_BASE, 8'h03);
      rdchk(gwe_pkg::ADDR_DATA_BASE, 8'h00);
      @(posedge core_clk);
      board[0] <= 1'b0;
      wt(6);
      rdchk(gwe_pkg::ADDR_WAKE_STS, 8'h01);
      wr(gwe_pkg::ADDR_WAKE_STS, 8'h01);
      @(posedge core_clk);
      board[0] <= 1'b1;
      wt(6);
      rdchk(gwe_pkg::ADDR_WAKE_STS, 8'h00);
   endtask

   task automatic t_either_edge();
      wr(gwe_pkg::ADDR_MGMT_EN, 8'h02);
      @(posedge core_clk);
      board[9] <= 1'b1;
      wt(6);
      rdchk(gwe_pkg::ADDR_SUMM_STS, 8'h01);
      rdchk(gwe_pkg::ADDR_MGMT_STS, 8'h02);
      chk({7'h00, mgmt_irq}, 8'h00);
      wr(gwe_pkg::ADDR_SUMM_STS, 8'h01);
      wr(gwe_pkg::ADDR_MGMT_STS, 8'h02);
      wr(gwe_pkg::ADDR_WAKE_STS + 8'd1, 8'h02);
      wr(gwe_pkg::ADDR_EE_MODE, 8'h01);
      wr(gwe_pkg::ADDR_CFG_BASE + 8'd9, 8'h00);
      wt(2);
      chk({7'h00, pin_oe[9]}, 8'h00);
      @(posedge core_clk);
      board[9] <= 1'b0;
      wt(6);
      rdchk(gwe_pkg::ADDR_SUMM_STS, 8'h01);
      rdchk(gwe_pkg::ADDR_WAKE_STS + 8'd1, 8'h02);
      chk({7'h00, mgmt_irq}, 8'h01);
   endtask

   task automatic t_fan();
      wr(gwe_pkg::ADDR_MGMT_STS, 8'h02);
      wt(2);
      chk({7'h00, mgmt_irq}, 8'h00);
      @(posedge core_clk);
      fan1 <= 1'b1;
      fan2 <= 1'b1;
      wt(6);
      rdchk(gwe_pkg::ADDR_MGMT_STS + 8'd2, 8'h30);
      chk({7'h00, mgmt_irq}, 8'h00);
      wr(gwe_pkg::ADDR_MGMT_EN + 8'd2, 8'h10);
      wt(2);
      chk({7'h00, mgmt_irq}, 8'h01);
   endtask

   // Alternate functions; each value differs from what the plain port would drive
   task automatic t_alt();
      wr(gwe_pkg::ADDR_CFG_BASE + 8'd4, 8'h02);
      wr(gwe_pkg::ADDR_CFG_BASE + 8'd27, 8'h02);
      wr(gwe_pkg::ADDR_CFG_BASE + 8'd15, 8'h80);
      wr(gwe_pkg::ADDR_DATA_BASE + 8'd1, 8'h80);
      wr(gwe_pkg::ADDR_CTRL, 8'h0f);
      wt(2);
      chk({4'h0, pin_oe[4], pin_out[4], pin_oe[5], pin_out[5]}, 8'h02);
      chk({6'h00, pin_oe[27], pin_out[27]}, 8'h02);
      chk({6'h00, pin_oe[15], pin_out[15]}, 8'h02);
      wr(gwe_pkg::ADDR_CFG_BASE + 8'd15, 8'h82);
      wt(2);
      chk({6'h00, pin_oe[15], pin_out[15]}, 8'h00);
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      print_verdict();
   end

   initial begin
      bad_count = 0;
      checked   = 0;
      rstn      = 1'b0;
      addr      = 8'h00;
      wdata     = 8'h00;
      wr_stb    = 1'b0;
      rd_stb    = 1'b0;
      board     = 48'h0;
      fan1      = 1'b0;
      fan2      = 1'b0;
      joy       = 4'h1;
      drate     = 1'b0;
      repeat (4) @(posedge core_clk);
      rstn <= 1'b1;
      t_reset();
      t_output();
      t_wake();
      t_either_edge();
      t_fan();
      t_alt();
      print_verdict();
   end
endmodule
`default_nettype wire
